// file: src/tpc_pkg.sv
// shared constants and types for the test pattern capture trigger
package tpc_pkg;
   // ==========================================================
   // sizes
   // ==========================================================
   localparam int CAP_LOG2_DEF = 27;  // 128 Mbit single-channel depth
   localparam int BC_LOG2_MAX  = 7;   // up to 128 blocks
   localparam int PAT_MAX      = 64;  // longest match pattern, bits
   localparam int PAT_STEP     = 4;   // pattern length granule, bits

   // ==========================================================
   // encodings
   // ==========================================================
   // trigger source
   typedef enum logic [1:0] {
      TRIG_ERR    = 2'h0,
      TRIG_MATCH  = 2'h1,
      TRIG_MANUAL = 2'h2,
      TRIG_EXT    = 2'h3
   } tpc_trig_t;

   // window placement around the trigger point; 2'h3 acts as top
   typedef enum logic [1:0] {
      POS_TOP = 2'h0,
      POS_MID = 2'h1,
      POS_BOT = 2'h2,
      POS_RSV = 2'h3
   } tpc_pos_t;

   // channel combining, value is log2 of the size factor
   localparam logic [1:0] COMB_SINGLE = 2'h0;
   localparam logic [1:0] COMB_DUAL   = 2'h1;
   localparam logic [1:0] COMB_QUAD   = 2'h2;

   // capture sequencer, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_ARM  = 3'h2,
      ST_POST = 3'h4
   } tpc_state_t;

   // ==========================================================
   // reset values
   // ==========================================================
   localparam logic [2:0] RST_BC   = 3'h0;
   localparam logic [3:0] RST_LEN  = 4'hF;
   localparam logic       RST_AUX  = 1'h1;  // aux input idles high
endpackage : tpc_pkg

// file: src/tpc_match.sv
// masked match-pattern detector on the received bit stream
`timescale 1ns/1ps
module tpc_match #(
   parameter int PW = tpc_pkg::PAT_MAX,
   parameter int LW = $clog2(PW / tpc_pkg::PAT_STEP)
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst_b,
   // stream
   input  wire logic          en,
   input  wire logic          bit_in,
   // pattern setup
   input  wire logic [PW-1:0] pattern,
   input  wire logic [PW-1:0] mask,
   input  wire logic [LW-1:0] len_code,
   input  wire logic [1:0]    comb,
   // results
   output logic               hit,
   output logic               pat_ok
);
   // ==========================================================
   // checks and storage
   // ==========================================================
   generate
      if (PW < tpc_pkg::PAT_STEP || PW % tpc_pkg::PAT_STEP != 0) begin : g_bad
         $error("tpc_match: pattern width must be a multiple of 4");
      end
   endgenerate

   logic [PW-1:0]   hist_r;   // newest bit in bit 0
   logic [PW-1:0]   hist_nxt;
   logic [PW-1:0]   in_len;   // bits inside the set length
   logic [LW+2:0]   fill_r;   // bits seen since enabled
   logic            hit_r;
   logic [PW/2-1:0] d_ok;     // per pair, mask uniform
   logic [PW/4-1:0] q_ok;     // per nibble, mask uniform

   // a group is clean when its mask bits agree
   function automatic logic grp_same(input logic [3:0] g,
                                     input logic       quad);
      grp_same = quad ? (g == 4'h0 || g == 4'hF) : (g[0] == g[1]);
   endfunction : grp_same

   // ==========================================================
   // decode
   // ==========================================================
   assign hist_nxt = {hist_r[PW-2:0], bit_in};

   // length decode and alignment per group
   genvar gi;
   generate
      for (gi = 0; gi < PW; gi++) begin : g_len
         assign in_len[gi] = (int'(len_code) >= gi / tpc_pkg::PAT_STEP);
      end
      for (gi = 0; gi < PW / 2; gi++) begin : g_dual
         assign d_ok[gi] = !in_len[2*gi] ||
            grp_same({2'h0, mask[2*gi+1:2*gi]}, 1'b0);
      end
      for (gi = 0; gi < PW / 4; gi++) begin : g_quad
         assign q_ok[gi] = !in_len[4*gi] ||
            grp_same(mask[4*gi+3:4*gi], 1'b1);
      end
   endgenerate

   // combining asks for whole 2- or 4-bit groups
   always_comb begin
      case (comb)
         tpc_pkg::COMB_SINGLE: pat_ok = 1'b1;
         tpc_pkg::COMB_DUAL:   pat_ok = &d_ok;
         tpc_pkg::COMB_QUAD:   pat_ok = &q_ok;
         default:              pat_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // history and compare
   // ==========================================================
   // history shifts only while matching is selected
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         hist_r <= '0;
         fill_r <= '0;
      end else if (!en) begin
         fill_r <= '0;
      end else begin
         hist_r <= hist_nxt;
         if (fill_r < (LW+3)'(PW)) begin
            fill_r <= fill_r + 1'b1;
         end
      end
   end

   // mask bit one drops that bit from the compare
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         hit_r <= 1'b0;
      end else begin
         hit_r <= en &&
            (fill_r >= (LW+3)'({len_code, 2'h3})) &&
            ~|((hist_nxt ^ pattern) & ~mask & in_len);
      end
   end

   assign hit = hit_r;
endmodule : tpc_match

// file: src/tpc_capture.sv
// test pattern capture sequencer with trigger selection
//
// Behaviour
// - start lights active and waits for trigger
// - memory filled ends capture, active cleared
// - refuse start in quick sync or sequence
// - block count 1 to 128, powers two
// - block size is depth over block count
// - dual combining doubles, quad quadruples block
// - bit error trigger starts storing
// - pattern hit trigger starts storing
// - each operator request while armed captures one block
// - aux input falling edge starts storing
// - pattern length 4 to 64, step 4
// - pattern settings act only for pattern trigger
// - mask one excludes that pattern bit
// - window placed after, around or before trigger
// - misaligned pattern under combining blocks start
`timescale 1ns/1ps
module tpc_capture #(
   parameter int CAP_LOG2 = tpc_pkg::CAP_LOG2_DEF,
   parameter int PW       = tpc_pkg::PAT_MAX,
   parameter int LW       = $clog2(PW / tpc_pkg::PAT_STEP),
   parameter int AW       = CAP_LOG2 + 2
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst_b,
   // received stream
   input  wire logic          rx_bit,
   input  wire logic          rx_err,
   // trigger sources
   input  wire logic          man_trig,
   input  wire logic          aux_in,
   // commands
   input  wire logic          cap_start,
   input  wire logic          cap_abort,
   input  wire logic          cfg_apply,
   // receiver modes
   input  wire logic          sync_quick,
   input  wire logic          pat_sequence,
   // staged setup, taken on cfg_apply
   input  wire logic [2:0]    block_count,
   input  wire logic          dual_channel_combining,
   input  wire logic          quad_channel_combining,
   input  wire logic [1:0]    trig_type,
   input  wire logic [1:0]    cap_pos,
   input  wire logic [LW-1:0] match_len,
   input  wire logic [PW-1:0] match_pattern,
   input  wire logic [PW-1:0] match_mask,
   // status
   output logic               capture_active,
   output logic               capture_done,
   output logic               start_refused,
   output logic [7:0]         blocks_captured,
   output logic [AW-1:0]      trig_addr,
   // capture memory write port
   output logic               mem_we,
   output logic [AW-1:0]      mem_addr,
   output logic               mem_data
);
   // ==========================================================
   // elaboration checks
   // ==========================================================
   generate
      if (CAP_LOG2 < tpc_pkg::BC_LOG2_MAX + 1 || CAP_LOG2 > 40 ||
          AW != CAP_LOG2 + 2) begin : g_bad
         $error("tpc_capture: depth must cover 128 blocks");
      end
   endgenerate

   // ==========================================================
   // declarations
   // ==========================================================
   // applied setup, changed only while idle
   logic [2:0]            bc_r;       // log2 of block count
   logic [1:0]            comb_r;     // log2 of combine factor
   tpc_pkg::tpc_trig_t    trig_r;
   tpc_pkg::tpc_pos_t     pos_r;
   logic [LW-1:0]         len_r;
   logic [PW-1:0]         pat_r;
   logic [PW-1:0]         mask_r;
   // sequencer
   tpc_pkg::tpc_state_t   state_r;
   logic [7:0]            blk_r;      // block being filled
   logic [AW-1:0]         off_r;      // write offset in block
   logic [AW:0]           post_r;     // bits still to store
   logic                  active_r;
   logic                  done_r;
   logic                  refuse_r;
   logic                  aux_prev_r;
   logic [AW-1:0]         trig_addr_r;
   logic                  mem_we_r;
   logic [AW-1:0]         mem_addr_r;
   logic                  mem_data_r;
   // decode
   logic [5:0]            sz_sh;      // log2 of block size
   logic [AW-1:0]         off_mask;
   logic [AW-1:0]         cur_addr;
   logic [AW:0]           post_init;
   logic [1:0]            comb_in;
   logic                  pat_hit;
   logic                  pat_ok;
   logic                  trig_evt;
   logic                  start_ok;
   logic                  st_arm;
   logic                  st_post;
   logic                  st_idle;
   logic                  wr_en;
   logic                  blk_end;
   logic                  last_blk;

   // ==========================================================
   // setup
   // ==========================================================
   // quad wins when both combining bits are set
   assign comb_in = quad_channel_combining ? tpc_pkg::COMB_QUAD :
                    dual_channel_combining ? tpc_pkg::COMB_DUAL :
                    tpc_pkg::COMB_SINGLE;

   // staged values land only on a confirm while idle
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         bc_r   <= tpc_pkg::RST_BC;
         comb_r <= tpc_pkg::COMB_SINGLE;
         trig_r <= tpc_pkg::TRIG_ERR;
         pos_r  <= tpc_pkg::POS_TOP;
         len_r  <= LW'(tpc_pkg::RST_LEN);
         pat_r  <= '0;
         mask_r <= '0;
      end else if (cfg_apply && st_idle) begin
         bc_r   <= block_count;
         comb_r <= comb_in;
         trig_r <= tpc_pkg::tpc_trig_t'(trig_type);
         pos_r  <= tpc_pkg::tpc_pos_t'(cap_pos);
         len_r  <= match_len;
         pat_r  <= match_pattern;
         mask_r <= match_mask;
      end
   end

   // ==========================================================
   // trigger sources
   // ==========================================================
   // pattern history runs only with the pattern trigger chosen
   tpc_match #(.PW(PW), .LW(LW)) u_match (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .en       (trig_r == tpc_pkg::TRIG_MATCH),
      .bit_in   (rx_bit),
      .pattern  (pat_r),
      .mask     (mask_r),
      .len_code (len_r),
      .comb     (comb_r),
      .hit      (pat_hit),
      .pat_ok   (pat_ok)
   );

   // aux input is synchronous already, one stage finds the edge
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         aux_prev_r <= tpc_pkg::RST_AUX;
      end else begin
         aux_prev_r <= aux_in;
      end
   end

   // pick the selected trigger
   always_comb begin
      case (trig_r)
         tpc_pkg::TRIG_ERR:    trig_evt = rx_err;
         tpc_pkg::TRIG_MATCH:  trig_evt = pat_hit;
         tpc_pkg::TRIG_MANUAL: trig_evt = man_trig;
         tpc_pkg::TRIG_EXT:    trig_evt = aux_prev_r && !aux_in;
         default:              trig_evt = 1'b0;
      endcase
   end

   // ==========================================================
   // block geometry
   // ==========================================================
   // size is depth over count, scaled by the combine factor
   assign sz_sh = 6'(CAP_LOG2) - {3'h0, bc_r} + {4'h0, comb_r};
   assign off_mask = AW'(((AW+1)'(1) << sz_sh) - (AW+1)'(1));
   assign cur_addr = (AW'(blk_r) << sz_sh) | (off_r & off_mask);
   assign last_blk = ({1'b0, blk_r} + 9'h1) == (9'h1 << bc_r);

   // bits kept after the trigger bit for each placement
   always_comb begin
      case (pos_r)
         tpc_pkg::POS_MID: post_init = {1'b0, off_mask >> 1};
         tpc_pkg::POS_BOT: post_init = '0;
         default:          post_init = {1'b0, off_mask};
      endcase
   end

   // ==========================================================
   // sequencer
   // ==========================================================
   assign st_idle = (state_r == tpc_pkg::ST_IDLE);
   assign st_arm  = (state_r == tpc_pkg::ST_ARM);
   assign st_post = (state_r == tpc_pkg::ST_POST);

   // quick sync, sequence source or a bad pattern block a start
   assign start_ok = cap_start && st_idle && !sync_quick &&
                     !pat_sequence &&
                     (trig_r != tpc_pkg::TRIG_MATCH || pat_ok);

   // middle and bottom keep a ring of pre-trigger bits
   assign wr_en = (st_arm && (trig_evt || pos_r == tpc_pkg::POS_MID ||
                              pos_r == tpc_pkg::POS_BOT)) || st_post;

   assign blk_end = !cap_abort &&
                    ((st_arm && trig_evt && post_init == '0) ||
                     (st_post && post_r == (AW+1)'(1)));

   // state steps; abort drops back without completion
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_r <= tpc_pkg::ST_IDLE;
      end else begin
         case (state_r)
            tpc_pkg::ST_IDLE: begin
               if (start_ok) begin
                  state_r <= tpc_pkg::ST_ARM;
               end
            end
            tpc_pkg::ST_ARM: begin
               if (cap_abort) begin
                  state_r <= tpc_pkg::ST_IDLE;
               end else if (blk_end) begin
                  state_r <= last_blk ? tpc_pkg::ST_IDLE
                                      : tpc_pkg::ST_ARM;
               end else if (trig_evt) begin
                  state_r <= tpc_pkg::ST_POST;
               end
            end
            tpc_pkg::ST_POST: begin
               if (cap_abort) begin
                  state_r <= tpc_pkg::ST_IDLE;
               end else if (blk_end) begin
                  // next block waits for a fresh trigger
                  state_r <= last_blk ? tpc_pkg::ST_IDLE
                                      : tpc_pkg::ST_ARM;
               end
            end
            default: state_r <= tpc_pkg::ST_IDLE;
         endcase
      end
   end

   // offset and remaining count inside the current block
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         off_r  <= '0;
         post_r <= '0;
      end else if (start_ok || blk_end) begin
         off_r  <= '0;
      end else if (wr_en) begin
         off_r  <= (off_r + 1'b1) & off_mask;
         if (st_arm) begin
            post_r <= post_init;
         end else begin
            post_r <= post_r - 1'b1;
         end
      end
   end

   // blocks count up in order; the final value is the total
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         blk_r <= '0;
      end else if (start_ok) begin
         blk_r <= '0;
      end else if (blk_end) begin
         blk_r <= blk_r + 8'h01;
      end
   end

   // ==========================================================
   // status
   // ==========================================================
   // active from accepted start to last block or abort
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         active_r <= 1'b0;
         done_r   <= 1'b0;
         refuse_r <= 1'b0;
      end else begin
         done_r   <= blk_end && last_blk;
         refuse_r <= cap_start && st_idle && !start_ok;
         if (start_ok) begin
            active_r <= 1'b1;
         end else if (cap_abort || (blk_end && last_blk)) begin
            active_r <= 1'b0;
         end
      end
   end

   // write port and trigger position, all registered
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         mem_we_r    <= 1'b0;
         mem_addr_r  <= '0;
         mem_data_r  <= 1'b0;
         trig_addr_r <= '0;
      end else begin
         mem_we_r   <= wr_en && !cap_abort;
         mem_addr_r <= cur_addr;
         mem_data_r <= rx_bit;
         if (st_arm && trig_evt) begin
            trig_addr_r <= cur_addr;
         end
      end
   end

   assign capture_active  = active_r;
   assign capture_done    = done_r;
   assign start_refused   = refuse_r;
   assign blocks_captured = blk_r;
   assign trig_addr       = trig_addr_r;
   assign mem_we          = mem_we_r;
   assign mem_addr        = mem_addr_r;
   assign mem_data        = mem_data_r;

   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_clean_start;
      st_idle && cap_start && !sync_quick && !pat_sequence &&
      trig_r != tpc_pkg::TRIG_MATCH;
   endsequence

   sequence s_trig_stored;
      ##1 mem_we_r && trig_addr_r == $past(cur_addr);
   endsequence

   a_start_arms: assert property (s_clean_start |=>
      capture_active && st_arm && blk_r == 8'h00)
      else $error("accepted start did not arm");
   a_refuse_mode: assert property (
      st_idle && cap_start && (sync_quick || pat_sequence) |=>
      start_refused && !capture_active)
      else $error("start not refused in blocked mode");
   a_bad_pattern: assert property (
      st_idle && cap_start && trig_r == tpc_pkg::TRIG_MATCH &&
      !pat_ok |=> start_refused && st_idle)
      else $error("misaligned pattern started capture");
   a_done_clears: assert property (
      capture_done |-> !capture_active && $past(capture_active) &&
      {1'b0, blk_r} == (9'h1 << bc_r))
      else $error("completion without all blocks");
   a_blk_range: assert property (
      capture_active |-> {1'b0, blk_r} < (9'h1 << bc_r))
      else $error("block index past block count");
   a_addr_block: assert property (
      mem_we_r |-> (mem_addr_r >> sz_sh) == AW'($past(blk_r)))
      else $error("write outside current block");
   a_err_trig: assert property (
      st_arm && trig_r == tpc_pkg::TRIG_ERR && rx_err && !cap_abort
      |-> s_trig_stored)
      else $error("bit error did not start storing");
   a_ext_fall: assert property (
      st_arm && trig_r == tpc_pkg::TRIG_EXT && aux_prev_r && !aux_in &&
      !cap_abort |-> s_trig_stored)
      else $error("aux falling edge did not start storing");
   a_bottom_end: assert property (
      st_arm && trig_evt && !cap_abort && pos_r == tpc_pkg::POS_BOT
      |=> blk_r == $past(blk_r) + 8'h01)
      else $error("bottom placement did not close the block");
endmodule : tpc_capture

// file: testbench/tpc_src.sv
// serial test data source that repeats one 64-bit word without end
`timescale 1ns/1ps
module tpc_src (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // word to repeat, newest bit is bit 0
   input  wire logic [63:0] word,
   // serial line toward the receiver
   output logic             rx_bit
);
   logic [5:0] idx_r;  // bit being sent, counts down
   // send bit 63 first so the history ends on bit 0, as the detector reads
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         idx_r <= 6'h3F;
      end else begin
         idx_r <= idx_r - 6'h01;
      end
   end
   assign rx_bit = word[idx_r];  // line is never idle, so no release level
endmodule : tpc_src

// file: testbench/tb_top.sv
// self-checking bench for the capture trigger sequencer
`timescale 1ns/1ps
module tb_top;
   // ==========================================================
   // settings and signals
   // ==========================================================
   localparam int CL = 8;           // shortened depth keeps runs brief
   localparam int AW = CL + 2;      // memory address width
   localparam logic [63:0] WRD = 64'h0123456789ABCDEF;  // source word
   logic sys_clk = 1'b0, rst_b = 1'b0, rx_bit, rx_err = 1'b0;
   logic man_trig = 1'b0, aux_in = 1'b1, cap_start = 1'b0;
   logic cap_abort = 1'b0;  // drops a running capture without completion
   logic cfg_apply = 1'b0, sync_quick = 1'b0, pat_sequence = 1'b0;
   logic [2:0] block_count = 3'h0;     // log2 of block count
   logic dual_channel_combining = 1'b0, quad_channel_combining = 1'b0;
   logic [1:0] trig_type = 2'h0, cap_pos = 2'h0;
   logic [63:0] match_mask = 64'h0;   // 1 excludes a bit
   logic capture_active, capture_done, start_refused, mem_we, mem_data;
   logic [7:0] blocks_captured;
   logic [AW-1:0] trig_addr, mem_addr;
   int n_mismatch = 0, n_tests = 0;

   always #20 sys_clk = ~sys_clk;  // 25 MHz

   tpc_src src (.sys_clk(sys_clk), .rst_b(rst_b), .word(WRD),
      .rx_bit(rx_bit));
   // pattern differs from the source only in bits 1:0, masked away later
   tpc_capture #(.CAP_LOG2(CL)) DUT (.sys_clk(sys_clk), .rst_b(rst_b),
      .rx_bit(rx_bit), .rx_err(rx_err), .man_trig(man_trig),
      .aux_in(aux_in), .cap_start(cap_start), .cap_abort(cap_abort),
      .cfg_apply(cfg_apply), .sync_quick(sync_quick),
      .pat_sequence(pat_sequence), .block_count(block_count),
      .dual_channel_combining(dual_channel_combining),
      .quad_channel_combining(quad_channel_combining),
      .trig_type(trig_type), .cap_pos(cap_pos), .match_len(4'hF),
      .match_pattern(WRD ^ 64'h3), .match_mask(match_mask),
      .capture_active(capture_active), .capture_done(capture_done),
      .start_refused(start_refused), .blocks_captured(blocks_captured),
      .trig_addr(trig_addr), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_data(mem_data));

   // ==========================================================
   // shared tasks
   // ==========================================================
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %0h expected %0h",
            $time, got, exp);
      end
   endtask : check

   // stage a setup and confirm it while idle
   task automatic cfg(input logic [2:0] bc, input logic [1:0] cm,
      input logic [1:0] tt, input logic [1:0] ps, input logic [63:0] mk);
      @(negedge sys_clk);
      block_count = bc;
      {quad_channel_combining, dual_channel_combining} = cm;
      trig_type = tt;
      cap_pos = ps;
      match_mask = mk;
      cfg_apply = 1'b1;
      @(negedge sys_clk);
      cfg_apply = 1'b0;
   endtask : cfg

   task automatic start(input logic ok);
      @(negedge sys_clk);
      cap_start = 1'b1;
      @(negedge sys_clk);
      cap_start = 1'b0;
      check(capture_active, ok);
      check(start_refused, !ok);
   endtask : start

   // fire one trigger per block and follow the writes to the block end;
   // pos is the placement: 0 top, 1 middle, 2 bottom
   task automatic fill(input int kind, input int nb, input int lg,
      input int pos);
      int nw;
      int t;
      int ne;
      int toff;
      logic fd;
      logic [AW-1:0] la;
      // writes from the trigger on: whole block, half, or trigger bit
      ne = (pos == 0) ? (1 << lg) : (pos == 1) ? (1 << (lg - 1)) : 1;
      // the ring runs two edges ahead of a middle or bottom trigger
      toff = (pos == 0) ? 0 : (2 % (1 << lg));
      for (int b = 0; b < nb; b++) begin
         nw = 0;
         fd = 1'bx;
         // pattern hits come from the source, others are driven here
         if (kind != 1) begin
            repeat (2) @(negedge sys_clk);
            rx_err = (kind == 0);
            man_trig = (kind == 2);
            aux_in = (kind != 3);
         end
         for (t = 0; t < 3000; t++) begin
            @(negedge sys_clk);
            rx_err = 1'b0;
            man_trig = 1'b0;
            aux_in = 1'b1;
            if (mem_we === 1'b1) begin
               nw++;
               la = mem_addr;
               if (nw == 1) fd = mem_data;
            end
            if (blocks_captured !== 8'(b)) break;
         end
         if (t == 3000) begin
            n_mismatch++;
            wrap_up();
         end
         check(nw, ne);
         check(trig_addr, (b << lg) | toff);
         check(la, (b << lg) | ((toff + ne - 1) % (1 << lg)));
         // the bit after the last pattern bit is the word's first bit
         if (kind == 1) check(fd, WRD[63]);
         check(capture_done, b == nb - 1);
      end
      check(capture_active, 1'b0);
      check(blocks_captured, nb);
   endtask : fill

   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic t_refuse;
      for (int i = 0; i < 2; i++) begin
         sync_quick = (i == 0);
         pat_sequence = (i == 1);
         start(1'b0);
      end
      sync_quick = 1'b0;
      pat_sequence = 1'b0;
      $display("test refuse done");
   endtask : t_refuse

   task automatic t_error;
      cfg(3'h0, 2'h0, 2'h0, 2'h0, 64'h0);
      start(1'b1);
      fill(0, 1, CL, 0);
      $display("test error trigger done");
   endtask : t_error

   // middle placement, then an abort that must not report completion
   task automatic t_middle;
      cfg(3'h0, 2'h0, 2'h2, 2'h1, 64'h0);
      start(1'b1);
      fill(2, 1, CL, 1);
      start(1'b1);
      @(negedge sys_clk);
      cap_abort = 1'b1;
      @(negedge sys_clk);
      cap_abort = 1'b0;
      check(capture_active, 1'b0);
      check(capture_done, 1'b0);
      $display("test middle and abort done");
   endtask : t_middle

   task automatic t_manual;
      cfg(3'h1, 2'h1, 2'h2, 2'h0, 64'h0);
      start(1'b1);
      fill(2, 2, CL, 0);
      $display("test operator trigger done");
   endtask : t_manual

   task automatic t_ext;
      cfg(3'h7, 2'h0, 2'h3, 2'h2, 64'h0);
      start(1'b1);
      fill(3, 128, 1, 2);
      $display("test aux trigger done");
   endtask : t_ext

   task automatic t_match;
      cfg(3'h0, 2'h1, 2'h1, 2'h0, 64'h1);
      start(1'b0);
      check(capture_active, 1'b0);
      cfg(3'h2, 2'h2, 2'h1, 2'h0, 64'hF);
      start(1'b1);
      fill(1, 4, CL, 0);
      $display("test match trigger done");
   endtask : t_match

   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      repeat (10) @(negedge sys_clk);
      rst_b = 1'b1;
      t_refuse();
      t_error();
      t_middle();
      t_manual();
      t_ext();
      t_match();
      wrap_up();
   end
endmodule : tb_top
